// ### shared/mttr_params.svh
// mode, interval and threshold register constants
// assumes inclusion by the mode register bank only
`ifndef MTTR_PARAMS_SVH
`define MTTR_PARAMS_SVH
`define MTTR_ADDR_MODE 8'h0a
`define MTTR_ADDR_IVL_HI 8'h0b
`define MTTR_ADDR_IVL_LO 8'h0c
`define MTTR_ADDR_LIM_HI 8'h0d
`define MTTR_ADDR_LIM_LO 8'h0e
`define MTTR_RST_MODE 8'h00
`define MTTR_RST_IVL_HI 8'h80
`define MTTR_RST_IVL_LO 8'h00
`define MTTR_RST_LIM_HI 8'h00
`define MTTR_RST_LIM_LO 8'h00
`define MTTR_BIT_RUN 0
`define MTTR_BIT_WAKE_EN 1
`define MTTR_BIT_UNIT 7
`define MTTR_MODE_MSB 7
`define MTTR_MODE_LSB 6
`define MTTR_CYC_MSB 5
`define MTTR_CYC_LSB 3
`define MTTR_CYC_BASE 4'h3
`define MTTR_CYC_MAX 4'ha
`define MTTR_IVL_HI_MSB 6
`define MTTR_RDATA_IDLE 8'h00
`endif

// ### shared/mttr_pkg.sv
// types for the mode, interval and threshold register bank
// assumes no other package
package mttr_pkg;
  typedef enum logic [1:0]
  {
    MTTR_NORMAL_ONE = 2'b00,
    MTTR_NORMAL_TWO = 2'b01,
    MTTR_LOW_POWER_ONE = 2'b10,
    MTTR_LOW_POWER_TWO = 2'b11
  } mttr_mode_t;
  typedef enum logic [2:0]
  {
    MTTR_ST_HALT = 3'b000,
    MTTR_ST_NORMAL_ONE = 3'b001,
    MTTR_ST_NORMAL_TWO = 3'b010,
    MTTR_ST_LOW_ONE = 3'b011,
    MTTR_ST_LOW_TWO = 3'b100
  } mttr_state_t;
endpackage

// ### core/mttr_regs.sv
// mode control, standby interval and current limit registers
// assumes a serial front end giving byte writes and reads on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "mttr_params.svh"
module mttr_regs
  import mttr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // configuration out
  output logic [14:0] standby_interval,
  output logic interval_in_seconds,
  output logic [15:0] standby_current_limit,
  output logic [3:0] compare_cycles,
  output mttr_mode_t target_mode,
  // state and pin
  output mttr_state_t op_state,
  output logic wake_indication_pin
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_standby(input mttr_state_t s);
    is_standby = (s == MTTR_ST_LOW_ONE) || (s == MTTR_ST_LOW_TWO);
  endfunction
  function automatic mttr_state_t mode_state(input mttr_mode_t m);
    case (m)
      MTTR_NORMAL_ONE: mode_state = MTTR_ST_NORMAL_ONE;
      MTTR_NORMAL_TWO: mode_state = MTTR_ST_NORMAL_TWO;
      MTTR_LOW_POWER_ONE: mode_state = MTTR_ST_LOW_ONE;
      default: mode_state = MTTR_ST_LOW_TWO;
    endcase
  endfunction

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] mode_reg, ivl_hi, ivl_lo, lim_hi, lim_lo;
  logic [7:0] next_mode_reg, next_ivl_hi, next_ivl_lo, next_lim_hi;
  logic [7:0] next_lim_lo, next_reg_rdata;
  logic [3:0] next_compare_cycles;

  always_comb
  begin
    next_mode_reg = mode_reg;
    next_ivl_hi = ivl_hi;
    next_ivl_lo = ivl_lo;
    next_lim_hi = lim_hi;
    next_lim_lo = lim_lo;
    next_reg_rdata = reg_rdata;
    if (reg_wr)
    begin
      case (reg_addr)
        `MTTR_ADDR_MODE: next_mode_reg = reg_wdata;
        `MTTR_ADDR_IVL_HI: next_ivl_hi = reg_wdata;
        `MTTR_ADDR_IVL_LO: next_ivl_lo = reg_wdata;
        `MTTR_ADDR_LIM_HI: next_lim_hi = reg_wdata;
        `MTTR_ADDR_LIM_LO: next_lim_lo = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `MTTR_ADDR_MODE: next_reg_rdata = mode_reg;
        `MTTR_ADDR_IVL_HI: next_reg_rdata = ivl_hi;
        `MTTR_ADDR_IVL_LO: next_reg_rdata = ivl_lo;
        `MTTR_ADDR_LIM_HI: next_reg_rdata = lim_hi;
        `MTTR_ADDR_LIM_LO: next_reg_rdata = lim_lo;
        default: next_reg_rdata = `MTTR_RDATA_IDLE;
      endcase
    end
    next_compare_cycles = `MTTR_CYC_BASE
      + {1'b0, next_mode_reg[`MTTR_CYC_MSB:`MTTR_CYC_LSB]};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= `MTTR_RST_MODE;
      ivl_hi <= `MTTR_RST_IVL_HI;
      ivl_lo <= `MTTR_RST_IVL_LO;
      lim_hi <= `MTTR_RST_LIM_HI;
      lim_lo <= `MTTR_RST_LIM_LO;
      reg_rdata <= `MTTR_RDATA_IDLE;
      // reset field code is zero
      compare_cycles <= `MTTR_CYC_BASE;
    end
    else
    begin
      mode_reg <= next_mode_reg;
      ivl_hi <= next_ivl_hi;
      ivl_lo <= next_ivl_lo;
      lim_hi <= next_lim_hi;
      lim_lo <= next_lim_lo;
      reg_rdata <= next_reg_rdata;
      compare_cycles <= next_compare_cycles;
    end
  end

  assign reg_hit = (reg_addr >= `MTTR_ADDR_MODE)
    && (reg_addr <= `MTTR_ADDR_LIM_LO);
  // unsigned count in the selected unit
  assign standby_interval =
    {ivl_hi[`MTTR_IVL_HI_MSB:0], ivl_lo};
  assign interval_in_seconds = ivl_hi[`MTTR_BIT_UNIT];
  assign standby_current_limit = {lim_hi, lim_lo};
  assign target_mode =
    mttr_mode_t'(mode_reg[`MTTR_MODE_MSB:`MTTR_MODE_LSB]);

  // ****************************************
  // operating state and wake pin
  // ****************************************
  mttr_state_t next_op_state;
  logic next_wake;

  always_comb
  begin
    next_op_state = op_state;
    if (!mode_reg[`MTTR_BIT_RUN])
      next_op_state = MTTR_ST_HALT;
    else
      next_op_state = mode_state(target_mode);
    next_wake = mode_reg[`MTTR_BIT_WAKE_EN] && is_standby(op_state)
      && !is_standby(next_op_state)
      && (next_op_state != MTTR_ST_HALT);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_state <= MTTR_ST_HALT;
      wake_indication_pin <= 1'b0;
    end
    else
    begin
      op_state <= next_op_state;
      wake_indication_pin <= next_wake;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_leave_standby;
    is_standby(op_state) ##1 (op_state == MTTR_ST_NORMAL_ONE
      || op_state == MTTR_ST_NORMAL_TWO);
  endsequence

  chk_wake_on_exit:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_leave_standby
        |-> (wake_indication_pin == $past(mode_reg[`MTTR_BIT_WAKE_EN])))
      else $error("wake pin wrong on standby exit");
  chk_wake_only_exit:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      wake_indication_pin |-> $past(is_standby(op_state))
        && !is_standby(op_state))
      else $error("wake pin without standby exit");
  chk_wake_single:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      wake_indication_pin |=> !wake_indication_pin)
      else $error("wake pin longer than one cycle");
  chk_halt_hold:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      !mode_reg[`MTTR_BIT_RUN] |=> op_state == MTTR_ST_HALT)
      else $error("left halt without run bit");
  chk_run_enter:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      mode_reg[`MTTR_BIT_RUN]
        |=> op_state == mode_state($past(target_mode)))
      else $error("run did not enter selected mode");
  chk_unit_bit:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == `MTTR_ADDR_IVL_HI
        |=> interval_in_seconds == $past(reg_wdata[`MTTR_BIT_UNIT]))
      else $error("unit bit not written");
  chk_ivl_join:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == `MTTR_ADDR_IVL_LO
        |=> standby_interval[7:0] == $past(reg_wdata))
      else $error("interval low byte wrong");
  chk_ivl_high:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == `MTTR_ADDR_IVL_HI
        |=> standby_interval
          == {$past(reg_wdata[`MTTR_IVL_HI_MSB:0]), ivl_lo})
      else $error("interval high bits wrong");
  chk_limit_high:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == `MTTR_ADDR_LIM_HI
        |=> standby_current_limit[15:8] == $past(reg_wdata))
      else $error("limit high byte wrong");
  chk_limit_low:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == `MTTR_ADDR_LIM_LO
        |=> standby_current_limit[7:0] == $past(reg_wdata))
      else $error("limit low byte wrong");
  chk_mode_map:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      mode_reg[`MTTR_BIT_RUN] && target_mode == MTTR_LOW_POWER_TWO
        |=> op_state == MTTR_ST_LOW_TWO)
      else $error("mode code 11 misrouted");
  chk_cycle_range:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      compare_cycles >= `MTTR_CYC_BASE && compare_cycles <= `MTTR_CYC_MAX)
      else $error("cycle count out of range");
  chk_cycle_write:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && reg_addr == `MTTR_ADDR_MODE
        |=> compare_cycles
          == `MTTR_CYC_BASE + $past(reg_wdata[`MTTR_CYC_MSB:`MTTR_CYC_LSB]))
      else $error("cycle count not taken from write");
  chk_ivl_hold:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      !reg_wr |=> $stable(standby_interval))
      else $error("interval changed without write");
endmodule // mttr_regs
`default_nettype wire

// ### testbench/tb_mode_timing_threshold_regs.sv
// bench for the mode, interval and limit register bank
// assumes mttr_regs on a 50 MHz sys_clk
`timescale 1ns/1ps
`default_nettype none
module tb_mode_timing_threshold_regs;
  import mttr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic [14:0] standby_interval;
  logic interval_in_seconds;
  logic [15:0] standby_current_limit;
  logic [3:0] compare_cycles;
  mttr_mode_t target_mode;
  mttr_state_t op_state;
  logic wake_indication_pin;
  int miscompares = 0;
  int checks = 0;
  logic [7:0] rv;
  int seen;
  logic [7:0] ra [5] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
  logic [7:0] rw [5] = '{8'h18, 8'h7f, 8'ha5, 8'h5a, 8'hc3};
  logic [7:0] rr [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  mttr_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .standby_interval(standby_interval),
    .interval_in_seconds(interval_in_seconds),
    .standby_current_limit(standby_current_limit),
    .compare_cycles(compare_cycles), .target_mode(target_mode),
    .op_state(op_state), .wake_indication_pin(wake_indication_pin));
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  // ****************
  // bus and checks
  // ****************
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    rv = reg_rdata;
  endtask
  // bounded look for a wake pulse
  task automatic watch();
    seen = 0;
    repeat (4)
    begin
      @(negedge sys_clk);
      if (wake_indication_pin === 1'b1)
        seen++;
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wr(ra[i], rw[i]);
      rd(ra[i]);
      chk("rd", 16'(rv), 16'(rw[i]));
      chk("hit", 16'(reg_hit), 16'h0001);
    end
    chk("ivl", 16'(standby_interval), 16'h7fa5);
    chk("unit", 16'(interval_in_seconds), 16'h0000);
    chk("lim", standby_current_limit, 16'h5ac3);
    chk("cyc", 16'(compare_cycles), 16'h0006);
    chk("halt", 16'(op_state), 16'(MTTR_ST_HALT));
    wr(8'h0a, 8'h38);
    chk("cyc", 16'(compare_cycles), 16'h000a);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h0a, {m[1:0], 6'h01});
      @(negedge sys_clk);
      chk("mode", 16'(target_mode), 16'(m));
      chk("st", 16'(op_state), 16'(m + 1));
    end
    wr(8'h0a, 8'hc3);
    @(negedge sys_clk);
    wr(8'h0a, 8'h03);
    watch();
    chk("wake", 16'(seen), 16'h0001);
    wr(8'h0a, 8'hc1);
    @(negedge sys_clk);
    wr(8'h0a, 8'h41);
    watch();
    chk("nowake", 16'(seen), 16'h0000);
    wr(8'h0a, 8'h40);
    @(negedge sys_clk);
    chk("halt", 16'(op_state), 16'(MTTR_ST_HALT));
    rd(8'h0f);
    chk("unmap", 16'(rv), 16'h0000);
    chk("hit", 16'(reg_hit), 16'h0000);
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i]);
      chk("rst", 16'(rv), 16'(rr[i]));
    end
    chk("unit", 16'(interval_in_seconds), 16'h0001);
    chk("rsthalt", 16'(op_state), 16'(MTTR_ST_HALT));
    chk("rstwake", 16'(wake_indication_pin), 16'h0000);
    chk("rstcyc", 16'(compare_cycles), 16'h0003);
    results();
  end
endmodule // tb_mode_timing_threshold_regs
`default_nettype wire
